// *** rtl/gwc_top.sv ***
/*
  Pin event wakeup counter with an AXI4-Lite register slave.
  Counts debounced active edges on selected pins and raises a wakeup
  interrupt when the programmed total is reached. Assumes asynchronous pins
  and a single 125 MHz clock; the bus master keeps AXI4-Lite signalling.
*/
`timescale 1ns/100ps
`include "gwc_defs.svh"
// Summary of operation
// - Per-pin select register chooses which pins feed the event counter.
// - With all pins selected, an active toggle on any pin can wake.
// - Polarity 0: rising edge on a selected pin sets the edge flag.
// - Active edge loads debounce timer from reload field; it counts millisecond ticks.
// - Debounce reload is six bits, zero to sixty-three milliseconds.
// - Timer at zero with edge still held increments the event counter.
// - After counting, wait for the opposite edge before accepting another.
// - Counter equal to target resets counter; interrupt raised when permitted.
// - Any write to interrupt clear port clears the pending interrupt.
// - Any write to counter clear port zeroes the event counter.
// - Counter readback register shows the live count without disturbing it.
// - Reaching the programmed count drives wake_irq only when irq_en and the mask bit are both set.
module gwc_top #(
  parameter int unsigned TICK_CYCLES = `GWC_TICK_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [`GWC_NPINS-1:0] pin_in,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic      [1:0]            s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       wake_irq
);

  logic [`GWC_NPINS-1:0] pin_sync;
  logic [`GWC_NPINS-1:0] pin_prev_r;
  logic                  tick;

  gwc_sync u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .pin_in   (pin_in),
    .pin_sync (pin_sync)
  );

  gwc_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk    (clk),
    .resetn (resetn),
    .tick   (tick)
  );

  // Configuration and status state.
  gwc_pkg::gwc_cfg_s     cfg_r;
  gwc_pkg::gwc_cfg_s     cfg_nxt;
  logic                  status_r;
  logic                  status_nxt;
  logic                  mask_r;
  logic                  mask_nxt;

  // Event counter state.
  gwc_pkg::gwc_state_e   state_r;
  gwc_pkg::gwc_state_e   state_nxt;
  logic [`GWC_DEB_W-1:0] deb_r;
  logic [`GWC_DEB_W-1:0] deb_nxt;
  logic [`GWC_CNT_W-1:0] count_r;
  logic [`GWC_CNT_W-1:0] count_nxt;
  logic [`GWC_NPINS-1:0] active_lvl;
  logic [`GWC_NPINS-1:0] act_edge;
  logic                  key_hit;
  logic                  any_edge;
  logic                  target_hit;

  // Bus slave state.
  logic        aw_full_r;
  logic        aw_full_nxt;
  logic [11:0] aw_addr_r;
  logic [11:0] aw_addr_nxt;
  logic        w_full_r;
  logic        w_full_nxt;
  logic [31:0] w_data_r;
  logic [31:0] w_data_nxt;
  logic [3:0]  w_strb_r;
  logic [3:0]  w_strb_nxt;
  logic        awready_nxt;
  logic        wready_nxt;
  logic        bvalid_nxt;
  logic [1:0]  bresp_nxt;
  logic        arready_nxt;
  logic        rvalid_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_nxt;
  logic        wr_fire;
  logic        rd_fire;
  logic        irq_clr_wr;
  logic        cnt_clr_wr;
  logic        status_rd;
  logic        irq_nxt;

  // Pin level that counts as active, per pin.
  // polarity select
  always_comb begin
    active_lvl = pin_sync ^ cfg_r.polarity;
    act_edge   = cfg_r.select & active_lvl & ~(pin_prev_r ^ cfg_r.polarity);
    any_edge   = |act_edge;
    key_hit    = |(cfg_r.select & active_lvl);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_prev_r <= `GWC_RST_SELECT;
    end else begin
      pin_prev_r <= pin_sync;
    end
  end

  // Event counter state machine.
  always_comb begin
    state_nxt  = state_r;
    deb_nxt    = deb_r;
    count_nxt  = count_r;
    target_hit = 1'b0;
    case (state_r)
      gwc_pkg::GWC_IDLE: begin
        if (any_edge) begin
          deb_nxt   = cfg_r.deb_reload;
          state_nxt = gwc_pkg::GWC_DEBOUNCE;
        end
      end
      gwc_pkg::GWC_DEBOUNCE: begin
        if (deb_r == '0) begin
          if (key_hit) begin
            count_nxt = count_r + 8'h01;
            state_nxt = gwc_pkg::GWC_HELD;
          end else begin
            state_nxt = gwc_pkg::GWC_IDLE;
          end
        end else if (tick) begin
          deb_nxt = deb_r - 6'h01;
        end
      end
      gwc_pkg::GWC_HELD: begin
        if (!key_hit) begin
          state_nxt = gwc_pkg::GWC_IDLE;
        end
      end
      default: begin
        state_nxt = gwc_pkg::GWC_IDLE;
      end
    endcase
    if (count_nxt == cfg_r.target && count_nxt != count_r) begin
      target_hit = 1'b1;
      count_nxt  = 8'h00;
    end
    if (cnt_clr_wr) begin
      count_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= gwc_pkg::GWC_IDLE;
      deb_r   <= 6'h00;
      count_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      deb_r   <= deb_nxt;
      count_r <= count_nxt;
    end
  end

  // Write channel: address and data are taken in either order.
  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt  = w_full_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    wr_fire     = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_full_r && w_full_r && !s_axi_bvalid) begin
      wr_fire     = 1'b1;
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `GWC_RESP_OKAY;
      if (aw_addr_r > `GWC_OFS_MASK || aw_addr_r[1:0] != 2'b00) begin
        bresp_nxt = `GWC_RESP_SLVERR;
      end
    end
    awready_nxt = !aw_full_nxt && !bvalid_nxt;
    wready_nxt  = !w_full_nxt && !bvalid_nxt;
  end

  // Register writes and write-side effects.
  always_comb begin
    cfg_nxt    = cfg_r;
    mask_nxt   = mask_r;
    irq_clr_wr = 1'b0;
    cnt_clr_wr = 1'b0;
    if (wr_fire) begin
      case (aw_addr_r)
        `GWC_OFS_SELECT: begin
          for (int b = 0; b < 4; b++) begin
            if (w_strb_r[b]) begin
              cfg_nxt.select[b*8 +: 8] = w_data_r[b*8 +: 8];
            end
          end
        end
        `GWC_OFS_POLARITY: begin
          for (int b = 0; b < 4; b++) begin
            if (w_strb_r[b]) begin
              cfg_nxt.polarity[b*8 +: 8] = w_data_r[b*8 +: 8];
            end
          end
        end
        `GWC_OFS_CTRL: begin
          if (w_strb_r[0]) begin
            cfg_nxt.deb_reload = w_data_r[`GWC_CTRL_DEB_LSB +: `GWC_DEB_W];
            cfg_nxt.irq_en     = w_data_r[`GWC_CTRL_IRQ_EN];
          end
        end
        `GWC_OFS_TARGET: begin
          if (w_strb_r[0]) begin
            cfg_nxt.target = w_data_r[`GWC_CNT_W-1:0];
          end
        end
        `GWC_OFS_IRQ_CLR: begin
          irq_clr_wr = 1'b1;
        end
        `GWC_OFS_CNT_CLR: begin
          cnt_clr_wr = 1'b1;
        end
        `GWC_OFS_MASK: begin
          if (w_strb_r[0]) begin
            mask_nxt = w_data_r[0];
          end
        end
        default: begin
          cfg_nxt = cfg_r;
        end
      endcase
    end
  end

  // Read channel: one outstanding read, answered the cycle after acceptance.
  always_comb begin
    rd_fire     = s_axi_arvalid && s_axi_arready;
    rvalid_nxt  = s_axi_rvalid;
    rdata_nxt   = s_axi_rdata;
    rresp_nxt   = s_axi_rresp;
    status_rd   = 1'b0;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `GWC_RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      case (s_axi_araddr)
        `GWC_OFS_SELECT:   rdata_nxt = cfg_r.select;
        `GWC_OFS_POLARITY: rdata_nxt = cfg_r.polarity;
        `GWC_OFS_CTRL: begin
          rdata_nxt[`GWC_CTRL_DEB_LSB +: `GWC_DEB_W] = cfg_r.deb_reload;
          rdata_nxt[`GWC_CTRL_IRQ_EN]                = cfg_r.irq_en;
        end
        `GWC_OFS_TARGET:   rdata_nxt[`GWC_CNT_W-1:0] = cfg_r.target;
        `GWC_OFS_IRQ_CLR:  rdata_nxt = 32'h0000_0000;
        `GWC_OFS_CNT_CLR:  rdata_nxt = 32'h0000_0000;
        `GWC_OFS_TALLY:    rdata_nxt[`GWC_CNT_W-1:0] = count_r;
        `GWC_OFS_STATUS: begin
          rdata_nxt[0] = status_r;
          status_rd    = 1'b1;
        end
        `GWC_OFS_MASK:     rdata_nxt[0] = mask_r;
        default:           rresp_nxt = `GWC_RESP_SLVERR;
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  // Sticky wakeup status; a new hit in the clearing cycle survives.
  always_comb begin
    status_nxt = status_r;
    if (irq_clr_wr || status_rd) begin
      status_nxt = 1'b0;
    end
    if (target_hit && cfg_r.irq_en) begin
      status_nxt = 1'b1;
    end
    irq_nxt = status_nxt && mask_nxt;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r.select     <= `GWC_RST_SELECT;
      cfg_r.polarity   <= `GWC_RST_POLARITY;
      cfg_r.deb_reload <= 6'(`GWC_RST_CTRL);
      cfg_r.irq_en     <= 1'b0;
      cfg_r.target     <= `GWC_RST_TARGET;
      mask_r           <= `GWC_RST_MASK;
      status_r         <= 1'b0;
      wake_irq         <= 1'b0;
      aw_full_r        <= 1'b0;
      aw_addr_r        <= 12'h000;
      w_full_r         <= 1'b0;
      w_data_r         <= 32'h0000_0000;
      w_strb_r         <= 4'h0;
      s_axi_awready    <= 1'b0;
      s_axi_wready     <= 1'b0;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= 2'b00;
      s_axi_arready    <= 1'b0;
      s_axi_rvalid     <= 1'b0;
      s_axi_rdata      <= 32'h0000_0000;
      s_axi_rresp      <= 2'b00;
    end else begin
      cfg_r            <= cfg_nxt;
      mask_r           <= mask_nxt;
      status_r         <= status_nxt;
      wake_irq         <= irq_nxt;
      aw_full_r        <= aw_full_nxt;
      aw_addr_r        <= aw_addr_nxt;
      w_full_r         <= w_full_nxt;
      w_data_r         <= w_data_nxt;
      w_strb_r         <= w_strb_nxt;
      s_axi_awready    <= awready_nxt;
      s_axi_wready     <= wready_nxt;
      s_axi_bvalid     <= bvalid_nxt;
      s_axi_bresp      <= bresp_nxt;
      s_axi_arready    <= arready_nxt;
      s_axi_rvalid     <= rvalid_nxt;
      s_axi_rdata      <= rdata_nxt;
      s_axi_rresp      <= rresp_nxt;
    end
  end

endmodule

// *** rtl/gwc_defs.svh ***
/*
  Register offsets, field positions, reset values and timing counts for the
  pin event wakeup counter. Assumes a 125 MHz clk and a 32-bit register bus.
*/
`ifndef GWC_DEFS_SVH
`define GWC_DEFS_SVH

`define GWC_NPINS          32
`define GWC_CNT_W          8
`define GWC_DEB_W          6

`define GWC_OFS_SELECT     12'h000
`define GWC_OFS_POLARITY   12'h004
`define GWC_OFS_CTRL       12'h008
`define GWC_OFS_TARGET     12'h00C
`define GWC_OFS_IRQ_CLR    12'h010
`define GWC_OFS_CNT_CLR    12'h014
`define GWC_OFS_TALLY      12'h018
`define GWC_OFS_STATUS     12'h01C
`define GWC_OFS_MASK       12'h020

`define GWC_CTRL_DEB_LSB   0
`define GWC_CTRL_IRQ_EN    7

`define GWC_RST_SELECT     32'h0000_0000
`define GWC_RST_POLARITY   32'h0000_0000
`define GWC_RST_CTRL       8'h00
`define GWC_RST_TARGET     8'h00
`define GWC_RST_MASK       1'b1

`define GWC_CLK_HZ         125000000
`define GWC_TICK_PERIOD_US 1000
`define GWC_TICK_CYCLES    ((`GWC_CLK_HZ / 1000000) * `GWC_TICK_PERIOD_US)

`define GWC_RESP_OKAY      2'b00
`define GWC_RESP_SLVERR    2'b10

`endif

// *** rtl/gwc_pkg.sv ***
/*
  Types shared by the pin event wakeup counter files.
  Assumes gwc_defs.svh is on the include path.
*/
`include "gwc_defs.svh"

package gwc_pkg;

  typedef enum logic [1:0] {
    GWC_IDLE     = 2'b00,
    GWC_DEBOUNCE = 2'b01,
    GWC_HELD     = 2'b11
  } gwc_state_e;

  typedef struct packed {
    logic [`GWC_NPINS-1:0] select;
    logic [`GWC_NPINS-1:0] polarity;
    logic [`GWC_DEB_W-1:0] deb_reload;
    logic                  irq_en;
    logic [`GWC_CNT_W-1:0] target;
  } gwc_cfg_s;

endpackage

// *** rtl/gwc_sync.sv ***
/*
  Two flip-flop synchroniser for the asynchronous pin bus.
  Assumes pins may change at any time relative to clk.
*/
`timescale 1ns/100ps
`include "gwc_defs.svh"

module gwc_sync (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [`GWC_NPINS-1:0] pin_in,
  output logic      [`GWC_NPINS-1:0] pin_sync
);

  logic [`GWC_NPINS-1:0] meta_r;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r   <= `GWC_RST_SELECT;
      pin_sync <= `GWC_RST_SELECT;
    end else begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule

// *** rtl/gwc_tick.sv ***
/*
  Millisecond tick generator: one-cycle pulse every GWC_TICK_CYCLES clocks.
  Assumes a free running clk at the rate in gwc_defs.svh.
*/
`timescale 1ns/100ps
`include "gwc_defs.svh"

module gwc_tick #(
  parameter int unsigned TICK_CYCLES = `GWC_TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic resetn,
  output logic      tick
);

  logic [16:0] cnt_r;
  logic [16:0] cnt_nxt;
  logic        tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + 17'h00001;
    if (cnt_r == 17'(TICK_CYCLES - 1)) begin
      cnt_nxt  = 17'h00000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 17'h00000;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule

// *** testbench/gwc_checker.sv ***
/*
  Bus timing and interrupt clear assertions for gwc_top.
  Assumes the bind below and gwc_defs.svh on the include path.
*/
`timescale 1ns/100ps
`include "gwc_defs.svh"
module gwc_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        wake_irq
);
  logic [11:0] wa_r, wa_nxt, ra_r, ra_nxt;
  function automatic logic bad(input logic [11:0] a);
    return (a[1:0] != 2'h0) || (a > `GWC_OFS_MASK);
  endfunction
  always_comb begin
    wa_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wa_r;
    ra_nxt = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_r;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wa_r <= 12'h000;
      ra_r <= 12'h000;
    end else begin
      wa_r <= wa_nxt;
      ra_r <= ra_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read answer");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during write answer");
  AST_RD_ERR: assert property (s_axi_rvalid && bad(ra_r)
    |-> s_axi_rresp == `GWC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read answer");
  AST_WR_ERR: assert property (s_axi_bvalid && bad(wa_r) |-> s_axi_bresp == `GWC_RESP_SLVERR)
    else $error("bad write answer");
  AST_RD_OK: assert property (s_axi_rvalid && !bad(ra_r) |-> s_axi_rresp == `GWC_RESP_OKAY)
    else $error("good read refused");
  AST_IRQ_CLR: assert property ($rose(s_axi_bvalid) && wa_r == `GWC_OFS_IRQ_CLR
    |-> ##[0:2] !wake_irq) else $error("interrupt not cleared");
  cover property ($rose(wake_irq));
  cover property (s_axi_rvalid && bad(ra_r));
  cover property ($rose(s_axi_bvalid) && wa_r == `GWC_OFS_CNT_CLR);
endmodule
bind gwc_top gwc_checker u_chk (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .wake_irq);

// *** testbench/gwc_pins.sv ***
/*
  External pin model: key or sensor levels driven onto the pin bus.
  Assumes the bench sets the wanted level vector between clock edges.
*/
`timescale 1ns/100ps
module gwc_pins (
  input  wire logic        clk,
  input  wire logic [31:0] level,
  output logic      [31:0] pin_in
);
  // Pins move on the clock so each event lands at a known cycle.
  initial pin_in = 32'h0000_0002;
  always @(posedge clk) pin_in <= level;
endmodule

// *** testbench/tb_top.sv ***
/*
  Register level test of gwc_top with a shortened millisecond tick.
  Assumes gwc_defs.svh on the include path and the pin model gwc_pins.
*/
`timescale 1ns/100ps
`include "gwc_defs.svh"
module tb_top;
  localparam int unsigned TICK = 10;
  logic        clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, wake_irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, pin_in, rdat;
  logic [31:0] level = 32'h0000_0002;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wrsp, rrsp;
  int          err_count = 0, check_count = 0, cyc = 0;
  logic [11:0] ofs [6] = '{`GWC_OFS_SELECT, `GWC_OFS_POLARITY, `GWC_OFS_CTRL,
                           `GWC_OFS_TARGET, `GWC_OFS_TALLY, `GWC_OFS_MASK};
  logic [31:0] rst [6] = '{`GWC_RST_SELECT, `GWC_RST_POLARITY, 32'(`GWC_RST_CTRL),
                           32'(`GWC_RST_TARGET), 32'h0, 32'(`GWC_RST_MASK)};
  gwc_pins u_pins (.clk(clk), .level(level), .pin_in(pin_in));
  gwc_top #(.TICK_CYCLES(TICK)) u_dut (.clk, .resetn, .pin_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wake_irq);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic print_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    wrsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(n, e, rdat);
  endtask
  task automatic hit(input int i, input int hold);
    level[i] <= ~level[i];
    repeat (hold) @(posedge clk);
    level[i] <= ~level[i];
    repeat (80) @(posedge clk);
  endtask
  task automatic irq(input logic e);
    repeat (3) @(posedge clk);
    chk("wake_irq", {31'h0, e}, {31'h0, wake_irq});
  endtask
  initial begin
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (ofs[k]) rchk("reset value", ofs[k], rst[k]);
    rchk("unmapped rdata", 12'h030, 32'h0);
    chk("unmapped rresp", {30'h0, `GWC_RESP_SLVERR}, {30'h0, rrsp});
    wr(12'h030, 32'h1);
    chk("unmapped bresp", {30'h0, `GWC_RESP_SLVERR}, {30'h0, wrsp});
    s_axi_wstrb <= 4'h2;
    wr(`GWC_OFS_SELECT, 32'hFFFF_FFFF);
    s_axi_wstrb <= 4'hF;
    rchk("select strobe", `GWC_OFS_SELECT, 32'h0000_FF00);
    wr(`GWC_OFS_POLARITY, 32'h2);
    wr(`GWC_OFS_SELECT, 32'h3);
    wr(`GWC_OFS_CTRL, 32'h82);
    wr(`GWC_OFS_TARGET, 32'h3);
    hit(0, 120);
    rchk("tally", `GWC_OFS_TALLY, 32'h1);
    hit(2, 60);
    rchk("tally", `GWC_OFS_TALLY, 32'h1);
    hit(1, 5);
    rchk("tally", `GWC_OFS_TALLY, 32'h1);
    hit(1, 60);
    rchk("tally", `GWC_OFS_TALLY, 32'h2);
    irq(1'b0);
    hit(0, 60);
    rchk("tally", `GWC_OFS_TALLY, 32'h0);
    irq(1'b1);
    wr(`GWC_OFS_IRQ_CLR, 32'h5A);
    irq(1'b0);
    hit(0, 60);
    wr(`GWC_OFS_CNT_CLR, 32'h0);
    rchk("tally", `GWC_OFS_TALLY, 32'h0);
    wr(`GWC_OFS_CTRL, 32'h02);
    repeat (3) hit(0, 60);
    rchk("tally", `GWC_OFS_TALLY, 32'h0);
    irq(1'b0);
    wr(`GWC_OFS_CTRL, 32'h82);
    wr(`GWC_OFS_MASK, 32'h0);
    repeat (3) hit(0, 60);
    irq(1'b0);
    rchk("status", `GWC_OFS_STATUS, 32'h1);
    rchk("status", `GWC_OFS_STATUS, 32'h0);
    wr(`GWC_OFS_MASK, 32'h1);
    wr(`GWC_OFS_CTRL, 32'hBF);
    rchk("ctrl", `GWC_OFS_CTRL, 32'hBF);
    hit(0, 400);
    rchk("tally", `GWC_OFS_TALLY, 32'h0);
    hit(0, 700);
    rchk("tally", `GWC_OFS_TALLY, 32'h1);
    wr(`GWC_OFS_CTRL, 32'h80);
    hit(0, 20);
    rchk("tally", `GWC_OFS_TALLY, 32'h2);
    wr(`GWC_OFS_SELECT, 32'h0);
    level[1] <= 1'b0;
    wr(`GWC_OFS_POLARITY, 32'h0);
    wr(`GWC_OFS_SELECT, 32'hFFFF_FFFF);
    hit(31, 20);
    rchk("tally", `GWC_OFS_TALLY, 32'h0);
    irq(1'b1);
    print_verdict();
  end
endmodule
